// ---- fifo_offset_defines.vh ----
// Purpose: constants for the offset load / retransmit block of a deep FIFO
// Assumes: included by its bare name from the design file
// Notes:   register offsets are byte addresses on APB, one aligned word each
//
// Overview of operation
// - offset writes fill registers in four-step wrapping order
// - offset write and read pointers advance independently
// - complete reset zeroes both pointers, partial keeps them
// - raising load select pauses programming, memory writes
// - pointer advances only on edges with strobe low
// - flag invalid until its own offset word written
// - full-side valid two write edges later, empty two reads
// - offset readback walks registers in same wrapping order
// - paused readback resumes where its pointer stopped
// - offset readback replaces the word on outputs
// - readback works in standard and fall-through timing
// - replay request low on read edge starts setup
// - standard: empty flag low during setup, pointer rewound
// - standard: every replayed word needs read strobe low
// - fall-through: output ready high during setup, rewound
// - fall-through: first word falls through when setup ends
// - almost-empty updates second read edge after setup
// - half-full updates on the setup read edge
// - almost-full updates second write edge after setup
// - load select low at reset: parallel, default 127
// - fall-through strap sampled at complete reset, kept after
`ifndef FIFO_OFFSET_DEFINES_VH
`define FIFO_OFFSET_DEFINES_VH

// register byte offsets
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_OFFSETS     12'h008

// control bits
`define CTRL_CR_BIT     0
`define CTRL_PR_BIT     1
`define CTRL_RESET      2'h0

// status field positions
`define STS_FT_BIT      0
`define STS_PAR_BIT     1
`define STS_WPTR_LSB    2
`define STS_RPTR_LSB    4
`define STS_EPEND_BIT   6
`define STS_FPEND_BIT   7
`define STS_SETUP_BIT   8
`define STS_OVALID_BIT  9
`define STS_COUNT_LSB   16
`define OFFS_FULL_LSB   16

// offset register indexes and default offsets
`define OFF_EMPTY_LO    2'h0
`define OFF_EMPTY_HI    2'h1
`define OFF_FULL_LO     2'h2
`define OFF_FULL_HI     2'h3
`define OFF_DEF_PAR     15'h007F
`define OFF_DEF_SER     15'h03FF

// partial-flag settling latency in strobe-clock edges
`define FLAG_LAT        2'h2

`endif

// ---- fifo_offset_load_retransmit.v ----
// Purpose: deep FIFO core with parallel offset load/readback and retransmit
// Assumes: write and read clocks arrive as pins, sampled on REF_CLK (25 MHz)
// Notes:   pin clocks must stay well below REF_CLK/4 so each edge is seen
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "fifo_offset_defines.vh"

module fifo_offset_load_retransmit #(
	parameter AW = 14,	// address bits, depth is 2**AW
	parameter DW = 9,	// data width
	parameter OW = 14	// offset width, not above AW
) (
	input  wire          REF_CLK,
	input  wire          RST_N,
	input  wire          WR_CLK,
	input  wire          RD_CLK,
	input  wire          WR_STROBE_N,
	input  wire          RD_STROBE_N,
	input  wire          OFFSET_LOAD_SELECT_N,
	input  wire          REPLAY_REQUEST_N,
	input  wire          FALL_THROUGH_MODE,
	input  wire          COMPLETE_RESET_N,
	input  wire          PARTIAL_RESET_N,
	input  wire [DW-1:0] DATA_INPUTS,
	output reg  [DW-1:0] DATA_OUTPUTS,
	output reg           EMPTY_FLAG_N,
	output reg           FULL_FLAG_N,
	output reg           ALMOST_EMPTY_FLAG_N,
	output reg           ALMOST_FULL_FLAG_N,
	output reg           HALF_FULL_FLAG_N,
	input  wire          PSEL,
	input  wire          PENABLE,
	input  wire          PWRITE,
	input  wire [11:0]   PADDR,
	input  wire [31:0]   PWDATA,
	output reg  [31:0]   PRDATA,
	output reg           PREADY,
	output reg           PSLVERR
);

	localparam SW = DW + 9;	// width of the sampled pin bundle
	localparam [AW:0] DEPTH_W = {1'b1, {AW{1'b0}}};	// word count when full
	localparam [AW:0] HALF_W  = {2'b01, {(AW-1){1'b0}}};	// half-full level
	localparam [DW-1:0] HI_MASK = {DW{1'b1}} >> (2*DW-OW);	// bits kept in high regs
	// idle pin levels: clocks low, strobes high, complete reset asserted
	localparam [SW-1:0] PIN_IDLE = {2'b00, 4'hF, 1'b0, 2'b01, {DW{1'b0}}};

	// default offset byte for one register, chosen by programming method
	function [DW-1:0] off_default;
		input       par;
		input [1:0] idx;
		reg   [2*DW-1:0] w;
		begin
			w = {{(2*DW-15){1'b0}}, (par ? `OFF_DEF_PAR : `OFF_DEF_SER)};
			off_default = idx[0] ? w[2*DW-1:DW] : w[DW-1:0];
		end
	endfunction

	reg  [SW-1:0] sync1_q;	// first stage, read only by second stage
	reg  [SW-1:0] sync2_q;	// second stage, safe to use
	reg           wclk_prev_q;	// delayed write clock for edge detect
	reg           rclk_prev_q;	// delayed read clock for edge detect

	wire          wclk_s   = sync2_q[DW+8];
	wire          rclk_s   = sync2_q[DW+7];
	wire          wen_n    = sync2_q[DW+6];
	wire          ren_n    = sync2_q[DW+5];
	wire          lsel_n   = sync2_q[DW+4];
	wire          replay_n = sync2_q[DW+3];
	wire          ft_pin   = sync2_q[DW+2];
	wire          cr_n     = sync2_q[DW+1];
	wire          pr_n     = sync2_q[DW];
	wire [DW-1:0] din      = sync2_q[DW-1:0];
	wire          w_edge   = wclk_s & ~wclk_prev_q;	// write clock rose
	wire          r_edge   = rclk_s & ~rclk_prev_q;	// read clock rose

	reg  [1:0]    ctrl_q;	// software reset requests
	wire          cr_act   = ~cr_n | ctrl_q[`CTRL_CR_BIT];
	wire          pr_act   = ~pr_n | ctrl_q[`CTRL_PR_BIT];

	reg           par_mode_q;	// parallel programming selected
	reg           ft_mode_q;	// fall-through timing selected
	reg  [DW-1:0] mem [0:(1<<AW)-1];	// FIFO storage
	reg  [DW-1:0] off_q [0:3];	// offset registers
	reg  [AW:0]   wr_ptr_q;	// memory write pointer
	reg  [AW:0]   rd_ptr_q;	// memory read pointer
	reg  [1:0]    woff_ptr_q;	// offset write pointer
	reg  [1:0]    roff_ptr_q;	// offset read pointer
	reg           e_pend_q;	// empty offset half written
	reg           f_pend_q;	// full offset half written
	reg           e_done_q;	// pulse: empty offset word completed
	reg  [1:0]    ae_wait_q;	// read edges left before almost-empty valid
	reg  [1:0]    af_wait_q;	// write edges left before almost-full valid
	reg           ae_p1_q;	// almost-empty pipeline stage
	reg           af_p1_q;	// almost-full pipeline stage
	reg           setup_q;	// retransmit setup in progress
	reg           out_valid_q;	// fall-through output holds a word
	reg  [31:0]   rd_word;	// APB read mux
	reg           rd_err;	// APB unmapped address

	wire [2*DW-1:0] e_cat  = {off_q[1], off_q[0]};
	wire [2*DW-1:0] f_cat  = {off_q[3], off_q[2]};
	wire [OW-1:0] e_off    = e_cat[OW-1:0];
	wire [OW-1:0] f_off    = f_cat[OW-1:0];
	wire [AW:0]   count    = wr_ptr_q - rd_ptr_q;	// words in memory
	wire          empty    = (count == {(AW+1){1'b0}});
	wire          full     = (count == DEPTH_W);
	wire [AW:0]   af_lvl   = DEPTH_W - {{(AW+1-OW){1'b0}}, f_off};
	wire          ae_cond  = (count <= {{(AW+1-OW){1'b0}}, e_off});
	wire          af_cond  = (count >= af_lvl);
	wire          off_wr   = ~lsel_n & ~wen_n & par_mode_q;
	wire          off_rd   = ~lsel_n & ~ren_n;

	// two-flop synchroniser for every FIFO-side pin (not the APB pins), plus clock edge history
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_q     <= PIN_IDLE;
			sync2_q     <= PIN_IDLE;
			wclk_prev_q <= 1'b0;
			rclk_prev_q <= 1'b0;
		end else begin
			sync1_q     <= {WR_CLK, RD_CLK, WR_STROBE_N, RD_STROBE_N,
				OFFSET_LOAD_SELECT_N, REPLAY_REQUEST_N, FALL_THROUGH_MODE,
				COMPLETE_RESET_N, PARTIAL_RESET_N, DATA_INPUTS};
			sync2_q     <= sync1_q;
			wclk_prev_q <= wclk_s;
			rclk_prev_q <= rclk_s;
		end
	end

	// straps are caught by the clock while complete reset is held
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			par_mode_q <= 1'b1;
			ft_mode_q  <= 1'b0;
		end else if (cr_act) begin
			par_mode_q <= ~lsel_n;
			ft_mode_q  <= ft_pin;	// partial reset leaves it
		end
	end

	// memory array has no reset, so it lives in its own process
	always @(posedge REF_CLK) begin
		if (!cr_act && !pr_act && w_edge && lsel_n && !wen_n && !full) begin
			mem[wr_ptr_q[AW-1:0]] <= din;
		end
	end

	// write side: offset loading, memory write pointer, almost-full flag
	always @(posedge REF_CLK or negedge RST_N) begin : wr_side
		integer i;
		if (!RST_N) begin
			for (i = 0; i < 4; i = i + 1) begin
				off_q[i] <= off_default(1'b1, i[1:0]);
			end
			wr_ptr_q           <= {(AW+1){1'b0}};
			woff_ptr_q         <= `OFF_EMPTY_LO;
			e_pend_q           <= 1'b0;
			f_pend_q           <= 1'b0;
			e_done_q           <= 1'b0;
			af_wait_q          <= 2'h0;
			af_p1_q            <= 1'b1;
			ALMOST_FULL_FLAG_N <= 1'b1;
		end else if (cr_act) begin
			// defaults follow the load select level seen during reset
			for (i = 0; i < 4; i = i + 1) begin
				off_q[i] <= off_default(~lsel_n, i[1:0]);
			end
			wr_ptr_q           <= {(AW+1){1'b0}};
			woff_ptr_q         <= `OFF_EMPTY_LO;
			e_pend_q           <= 1'b0;
			f_pend_q           <= 1'b0;
			e_done_q           <= 1'b0;
			af_wait_q          <= 2'h0;
			af_p1_q            <= 1'b1;
			ALMOST_FULL_FLAG_N <= 1'b1;
		end else if (pr_act) begin
			// offsets and the offset pointer survive a partial reset
			wr_ptr_q           <= {(AW+1){1'b0}};
			e_done_q           <= 1'b0;
			af_p1_q            <= 1'b1;
			ALMOST_FULL_FLAG_N <= 1'b1;
		end else begin
			e_done_q <= 1'b0;
			if (w_edge) begin
				if (off_wr) begin
					// strobe low with load select low stores next register
					if (woff_ptr_q[0]) begin
						off_q[woff_ptr_q] <= din & HI_MASK;
					end else begin
						off_q[woff_ptr_q] <= din;
					end
					woff_ptr_q <= woff_ptr_q + 2'h1;	// own pointer only
					case (woff_ptr_q)
						`OFF_EMPTY_LO: e_pend_q <= 1'b1;
						`OFF_EMPTY_HI: begin
							e_pend_q <= 1'b0;
							e_done_q <= 1'b1;	// read side starts its count
						end
						`OFF_FULL_LO:  f_pend_q <= 1'b1;
						default: begin
							f_pend_q <= 1'b0;
						end
					endcase
				end else if (lsel_n && !wen_n && !full) begin
					wr_ptr_q <= wr_ptr_q + {{AW{1'b0}}, 1'b1};
				end
				// two-stage pipeline: level sampled now shows on the next write edge
				af_p1_q <= ~af_cond;
				if (off_wr && woff_ptr_q == `OFF_FULL_HI) begin
					af_wait_q <= `FLAG_LAT;
				end else if (af_wait_q != 2'h0) begin
					af_wait_q <= af_wait_q - 2'h1;
				end
				// hold the output while its offset is incomplete or settling
				if (!f_pend_q && af_wait_q != `FLAG_LAT) begin
					ALMOST_FULL_FLAG_N <= af_p1_q;
				end
			end
		end
	end

	// read side: offset readback, memory reads, retransmit, almost-empty
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_ptr_q            <= {(AW+1){1'b0}};
			roff_ptr_q          <= `OFF_EMPTY_LO;
			DATA_OUTPUTS        <= {DW{1'b0}};
			setup_q             <= 1'b0;
			out_valid_q         <= 1'b0;
			ae_wait_q           <= 2'h0;
			ae_p1_q             <= 1'b0;
			ALMOST_EMPTY_FLAG_N <= 1'b0;
		end else if (cr_act || pr_act) begin
			// only complete reset moves the offset read pointer
			if (cr_act) begin
				roff_ptr_q <= `OFF_EMPTY_LO;
				ae_wait_q  <= 2'h0;
			end
			rd_ptr_q            <= {(AW+1){1'b0}};
			DATA_OUTPUTS        <= {DW{1'b0}};
			setup_q             <= 1'b0;
			out_valid_q         <= 1'b0;
			ae_p1_q             <= 1'b0;
			ALMOST_EMPTY_FLAG_N <= 1'b0;
		end else begin
			// completion pulse wins over a same-cycle countdown
			if (e_done_q) begin
				ae_wait_q <= `FLAG_LAT;
			end else if (r_edge && ae_wait_q != 2'h0) begin
				ae_wait_q <= ae_wait_q - 2'h1;
			end
			if (r_edge) begin
				// second read edge after setup carries the new level
				ae_p1_q <= ~ae_cond;
				if (!e_pend_q && ae_wait_q != `FLAG_LAT) begin
					ALMOST_EMPTY_FLAG_N <= ae_p1_q;
				end
				// relies on both strobes already high
				if (!replay_n) begin
					setup_q     <= 1'b1;
					rd_ptr_q    <= {(AW+1){1'b0}};	// rewind
					out_valid_q <= 1'b0;
				end else if (setup_q) begin
					setup_q <= 1'b0;
					// fall-through drops the first word without a strobe
					if (ft_mode_q && !empty) begin
						DATA_OUTPUTS <= mem[rd_ptr_q[AW-1:0]];
						rd_ptr_q     <= rd_ptr_q + {{AW{1'b0}}, 1'b1};
						out_valid_q  <= 1'b1;
					end
				end else if (off_rd) begin
					// overwrites the presented word in either timing
					DATA_OUTPUTS <= off_q[roff_ptr_q];
					roff_ptr_q   <= roff_ptr_q + 2'h1;	// resumes where left
				end else if (lsel_n && !ft_mode_q) begin
					// standard timing needs a strobe for every word
					if (!ren_n && !empty) begin
						DATA_OUTPUTS <= mem[rd_ptr_q[AW-1:0]];
						rd_ptr_q     <= rd_ptr_q + {{AW{1'b0}}, 1'b1};
					end
				end else if (lsel_n && (!out_valid_q || !ren_n)) begin
					// fall-through refills the output, later words on strobe
					if (!empty) begin
						DATA_OUTPUTS <= mem[rd_ptr_q[AW-1:0]];
						rd_ptr_q     <= rd_ptr_q + {{AW{1'b0}}, 1'b1};
						out_valid_q  <= 1'b1;
					end else begin
						out_valid_q  <= 1'b0;
					end
				end
			end
		end
	end

	// asynchronous-style flags, refreshed every reference cycle
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			EMPTY_FLAG_N     <= 1'b0;
			FULL_FLAG_N      <= 1'b1;
			HALF_FULL_FLAG_N <= 1'b1;
		end else if (cr_act || pr_act) begin
			// standard shows empty low, fall-through shows output-ready high
			EMPTY_FLAG_N     <= cr_act ? ft_pin : ft_mode_q;
			FULL_FLAG_N      <= 1'b1;
			HALF_FULL_FLAG_N <= 1'b1;
		end else begin
			if (ft_mode_q) begin
				EMPTY_FLAG_N <= setup_q | ~out_valid_q;
			end else begin
				EMPTY_FLAG_N <= ~setup_q & ~empty;
			end
			FULL_FLAG_N      <= ~full;
			// follows the rewound count right after the setup edge
			HALF_FULL_FLAG_N <= ~(count > HALF_W);
		end
	end

	// APB read data selection
	always @* begin
		rd_word = 32'h00000000;
		rd_err  = 1'b0;
		case (PADDR)
			`REG_CTRL: begin
				rd_word[1:0] = ctrl_q;
			end
			`REG_STATUS: begin
				rd_word[`STS_FT_BIT]                   = ft_mode_q;
				rd_word[`STS_PAR_BIT]                  = par_mode_q;
				rd_word[`STS_WPTR_LSB+1:`STS_WPTR_LSB] = woff_ptr_q;
				rd_word[`STS_RPTR_LSB+1:`STS_RPTR_LSB] = roff_ptr_q;
				rd_word[`STS_EPEND_BIT]                = e_pend_q;
				rd_word[`STS_FPEND_BIT]                = f_pend_q;
				rd_word[`STS_SETUP_BIT]                = setup_q;
				rd_word[`STS_OVALID_BIT]               = out_valid_q;
				rd_word[`STS_COUNT_LSB+AW:`STS_COUNT_LSB] = count;
			end
			`REG_OFFSETS: begin
				rd_word[OW-1:0]                          = e_off;
				rd_word[`OFFS_FULL_LSB+OW-1:`OFFS_FULL_LSB] = f_off;
			end
			default: begin
				rd_err = 1'b1;	// unmapped address answers with an error
			end
		endcase
	end

	// APB slave: one wait state, write lands on the completing edge
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q  <= `CTRL_RESET;
			PRDATA  <= 32'h00000000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else if (PSEL && PENABLE && !PREADY) begin
			PREADY  <= 1'b1;
			PRDATA  <= PWRITE ? 32'h00000000 : rd_word;
			PSLVERR <= rd_err;
		end else begin
			// transfer completes here; status and offsets are read-only
			if (PSEL && PENABLE && PWRITE && PADDR == `REG_CTRL) begin
				ctrl_q <= PWDATA[1:0];
			end
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

endmodule

// ---- fifo_offset_props.sv ----
// Purpose: pin-level checks for the offset load and retransmit block
// Assumes: pin clocks are slow, so each pin edge is seen on REF_CLK
// Notes:   eight-cycle windows cover the two-flop sync plus the update
`timescale 1ns/1ps
module fifo_offset_props #(
	parameter DW = 9
) (
	input wire          REF_CLK,
	input wire          RST_N,
	input wire          WR_CLK,
	input wire          RD_CLK,
	input wire          RD_STROBE_N,
	input wire          OFFSET_LOAD_SELECT_N,
	input wire          REPLAY_REQUEST_N,
	input wire          FALL_THROUGH_MODE,
	input wire          COMPLETE_RESET_N,
	input wire          PARTIAL_RESET_N,
	input wire [DW-1:0] DATA_OUTPUTS,
	input wire          EMPTY_FLAG_N,
	input wire          ALMOST_EMPTY_FLAG_N,
	input wire          ALMOST_FULL_FLAG_N
);
	reg       rd_q;     // last sampled read clock
	reg       wr_q;     // last sampled write clock
	reg [3:0] rd_age_q; // cycles since read clock rose
	reg [3:0] wr_age_q; // cycles since write clock rose
	reg [3:0] run_q;    // cycles since both reset pins high
	reg       ft_q;     // strap as caught in complete reset

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// ages saturate so that an old edge never looks fresh
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_q <= 1'h0;
			wr_q <= 1'h0;
			rd_age_q <= 4'hF;
			wr_age_q <= 4'hF;
			run_q <= 4'h0;
			ft_q <= 1'h0;
		end else begin
			rd_q <= RD_CLK;
			wr_q <= WR_CLK;
			rd_age_q <= (RD_CLK && !rd_q) ? 4'h0 : rd_age_q + {3'h0, rd_age_q != 4'hF};
			wr_age_q <= (WR_CLK && !wr_q) ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hF};
			run_q <= (COMPLETE_RESET_N && PARTIAL_RESET_N) ? run_q + {3'h0, run_q != 4'hF} : 4'h0;
			if (!COMPLETE_RESET_N)
				ft_q <= FALL_THROUGH_MODE;
		end
	end

	property p_out_moves;
		$changed(DATA_OUTPUTS) && run_q > 4'h8 |-> rd_age_q < 4'h8;
	endproperty
	a_out_moves: assert property (p_out_moves)
		else $error("output word moved with no read edge");
	property p_ae_moves;
		$changed(ALMOST_EMPTY_FLAG_N) && run_q > 4'h8 |-> rd_age_q < 4'h8;
	endproperty
	a_ae_moves: assert property (p_ae_moves)
		else $error("almost-empty moved with no read edge");
	property p_af_moves;
		$changed(ALMOST_FULL_FLAG_N) && run_q > 4'h8 |-> wr_age_q < 4'h8;
	endproperty
	a_af_moves: assert property (p_af_moves)
		else $error("almost-full moved with no write edge");
	property p_std_setup;
		$rose(RD_CLK) && !REPLAY_REQUEST_N && !ft_q && run_q > 4'h8 |-> ##[2:7] !EMPTY_FLAG_N;
	endproperty
	a_std_setup: assert property (p_std_setup)
		else $error("empty flag not low at replay setup");
	property p_ft_setup;
		$rose(RD_CLK) && !REPLAY_REQUEST_N && ft_q && run_q > 4'h8 |-> ##[2:7] EMPTY_FLAG_N;
	endproperty
	a_ft_setup: assert property (p_ft_setup)
		else $error("output ready not high at replay setup");
	property p_std_hold;
		$rose(RD_CLK) && RD_STROBE_N && !ft_q && run_q > 4'h8 |-> $stable(DATA_OUTPUTS)[*8];
	endproperty
	a_std_hold: assert property (p_std_hold)
		else $error("standard read without strobe moved the output");
	property p_strap;
		(!COMPLETE_RESET_N && $stable(FALL_THROUGH_MODE))[*8] |-> EMPTY_FLAG_N == FALL_THROUGH_MODE;
	endproperty
	a_strap: assert property (p_strap)
		else $error("empty or ready level does not follow strap");
	property p_reset_flags;
		(!COMPLETE_RESET_N)[*8] |-> !ALMOST_EMPTY_FLAG_N && ALMOST_FULL_FLAG_N && DATA_OUTPUTS == 0;
	endproperty
	a_reset_flags: assert property (p_reset_flags)
		else $error("flags or output wrong in complete reset");

	c_std_replay: cover property ($rose(RD_CLK) && !REPLAY_REQUEST_N && !ft_q);
	c_ft_replay: cover property ($rose(RD_CLK) && !REPLAY_REQUEST_N && ft_q);
	c_offs_read: cover property ($rose(RD_CLK) && !OFFSET_LOAD_SELECT_N && !RD_STROBE_N);
endmodule

bind fifo_offset_load_retransmit fifo_offset_props #(.DW(DW)) i_props (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .WR_CLK(WR_CLK), .RD_CLK(RD_CLK),
	.RD_STROBE_N(RD_STROBE_N), .OFFSET_LOAD_SELECT_N(OFFSET_LOAD_SELECT_N),
	.REPLAY_REQUEST_N(REPLAY_REQUEST_N), .FALL_THROUGH_MODE(FALL_THROUGH_MODE),
	.COMPLETE_RESET_N(COMPLETE_RESET_N), .PARTIAL_RESET_N(PARTIAL_RESET_N),
	.DATA_OUTPUTS(DATA_OUTPUTS), .EMPTY_FLAG_N(EMPTY_FLAG_N),
	.ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N), .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N));

// ---- fifo_host_model.sv ----
// Purpose: write-side and read-side host logic on the FIFO pins
// Assumes: tasks are entered right after a REF_CLK rising edge
// Notes:   pin clocks move only inside a transfer; released data is inverted
`timescale 1ns/1ps
module fifo_host_model (
	input  wire       ref_clk,
	output reg        wr_clk,
	output reg        rd_clk,
	output reg        wr_strobe_n,
	output reg        rd_strobe_n,
	output reg        offset_load_select_n,
	output reg        replay_request_n,
	output reg  [8:0] data_inputs
);
	// idle: load select low so a complete reset picks parallel offsets
	initial begin
		wr_clk = 1'h0;
		rd_clk = 1'h0;
		wr_strobe_n = 1'h1;
		rd_strobe_n = 1'h1;
		offset_load_select_n = 1'h0;
		replay_request_n = 1'h1;
		data_inputs = 9'h000;
	end

	// one write-clock period, c = {load select, write strobe}
	task automatic wr(input logic [1:0] c, input logic [8:0] d);
		offset_load_select_n <= c[1];
		wr_strobe_n <= c[0];
		data_inputs <= d;
		repeat (4) @(posedge ref_clk);
		wr_clk <= 1'h1;
		repeat (5) @(posedge ref_clk);
		wr_clk <= 1'h0;
		wr_strobe_n <= 1'h1;
		data_inputs <= ~d;
		repeat (4) @(posedge ref_clk);
	endtask

	// one read-clock period, c = {load select, read strobe, replay}
	// calls never overlap, so offset writes and reads never coincide
	task automatic rd(input logic [2:0] c);
		offset_load_select_n <= c[2];
		rd_strobe_n <= c[1] | ~c[0];
		replay_request_n <= c[0];
		repeat (4) @(posedge ref_clk);
		rd_clk <= 1'h1;
		repeat (5) @(posedge ref_clk);
		rd_clk <= 1'h0;
		rd_strobe_n <= 1'h1;
		replay_request_n <= 1'h1;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule

// ---- test_fifo_offset_load_retransmit.sv ----
// Purpose: offset programming, readback and replay through pins and APB
// Assumes: host model owns the pin side, this module owns resets and APB
// Notes:   expected words come from the order the offsets were written
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("BAD at %0t got %h expected %h", $time, a, e); end end
module test_fifo_offset_load_retransmit;
	logic        ref_clk, rst_n, crst_n, prst_n, ft;
	logic        psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, err;
	wire         wr_clk, rd_clk, wr_n, rd_n, lsel_n, replay_n;
	wire  [8:0]  din, dout;
	wire         empty_n, full_n, ae_n, af_n, half_n;
	int          num_checks, miscompares, i;

	fifo_host_model i_host (.ref_clk(ref_clk), .wr_clk(wr_clk), .rd_clk(rd_clk),
		.wr_strobe_n(wr_n), .rd_strobe_n(rd_n), .offset_load_select_n(lsel_n),
		.replay_request_n(replay_n), .data_inputs(din));
	fifo_offset_load_retransmit #(.AW(14), .DW(9), .OW(14)) i_dut (
		.REF_CLK(ref_clk), .RST_N(rst_n), .WR_CLK(wr_clk), .RD_CLK(rd_clk),
		.WR_STROBE_N(wr_n), .RD_STROBE_N(rd_n), .OFFSET_LOAD_SELECT_N(lsel_n),
		.REPLAY_REQUEST_N(replay_n), .FALL_THROUGH_MODE(ft), .COMPLETE_RESET_N(crst_n),
		.PARTIAL_RESET_N(prst_n), .DATA_INPUTS(din), .DATA_OUTPUTS(dout),
		.EMPTY_FLAG_N(empty_n), .FULL_FLAG_N(full_n), .ALMOST_EMPTY_FLAG_N(ae_n),
		.ALMOST_FULL_FLAG_N(af_n), .HALF_FULL_FLAG_N(half_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

	always #20 ref_clk = ~ref_clk;

	// the single exit: counts, then the verdict
	task end_of_test;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one APB transfer; the wait for pready is bounded so a dead slave ends the run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rdat = prdata;
		err = pslverr;
		if (pready !== 1'h1) begin
			miscompares++;
			end_of_test();
		end
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask

	// read a register and compare the masked word, no error allowed
	task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h00000000);
		`CHK(err, 1'h0)
		`CHK(rdat & m, e)
	endtask

	// one read-clock period, then the output word
	task automatic rx(input logic [2:0] c, input logic [8:0] e);
		i_host.rd(c);
		`CHK(dout, e)
	endtask

	// hold a reset pin low long enough for its synchroniser
	task automatic pulse_reset(input logic full);
		if (full)
			crst_n <= 1'h0;
		else
			prst_n <= 1'h0;
		repeat (10) @(posedge ref_clk);
		`CHK(empty_n, ft)
		crst_n <= 1'h1;
		prst_n <= 1'h1;
		repeat (8) @(posedge ref_clk);
	endtask

	initial begin
		{ref_clk, rst_n, crst_n, ft, psel, penable, pwrite} = 7'h00;
		{prst_n, paddr, pwdata} = {1'h1, 12'h000, 32'h00000000};
		num_checks = 0;
		miscompares = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		pulse_reset(1'h1);
		rchk(12'h004, 32'h0000003F, 32'h00000002);
		rchk(12'h008, 32'hFFFFFFFF, 32'h007F007F);
		apb(1'h1, 12'h000, 32'h00000000);
		rchk(12'h000, 32'h00000003, 32'h00000000);
		apb(1'h0, 12'h00C, 32'h00000000);
		`CHK({err, rdat}, {1'h1, 32'h00000000})
		i_host.wr(2'h0, 9'h015);
		i_host.wr(2'h0, 9'h01A);
		for (i = 1; i < 4; i++)
			i_host.wr(2'h2, 9'h0A0 + i[8:0]);
		i_host.wr(2'h1, 9'h1FF);
		i_host.wr(2'h0, 9'h033);
		i_host.wr(2'h0, 9'h005);
		i_host.wr(2'h0, 9'h044);
		rchk(12'h008, 32'hFFFFFFFF, {2'h0, 5'h05, 9'h033, 2'h0, 5'h1A, 9'h044});
		rx(3'h1, 9'h044);
		rx(3'h1, 9'h01A);
		rx(3'h5, 9'h0A1);
		rx(3'h1, 9'h033);
		rx(3'h1, 9'h005);
		rx(3'h1, 9'h044);
		rchk(12'h004, 32'h0000003F, 32'h00000016);
		rx(3'h6, 9'h044);
		`CHK(empty_n, 1'h0)
		rx(3'h7, 9'h044);
		`CHK({empty_n, half_n, ae_n}, 3'h6)
		`CHK({full_n, af_n}, 2'h3)
		rx(3'h5, 9'h0A1);
		rx(3'h5, 9'h0A2);
		pulse_reset(1'h0);
		// soft partial reset through the control register must keep both pointers too
		apb(1'h1, 12'h000, 32'h00000002);
		rchk(12'h000, 32'h00000003, 32'h00000002);
		apb(1'h1, 12'h000, 32'h00000000);
		rchk(12'h004, 32'h0000003F, 32'h00000016);
		i_host.rd(3'h3);
		ft <= 1'h1;
		pulse_reset(1'h1);
		rchk(12'h004, 32'h0000003F, 32'h00000003);
		i_host.wr(2'h2, 9'h0B1);
		i_host.wr(2'h2, 9'h0B2);
		repeat (3) i_host.rd(3'h7);
		`CHK({empty_n, dout}, {1'h0, 9'h0B1})
		rx(3'h1, 9'h07F);
		rx(3'h6, 9'h07F);
		`CHK(empty_n, 1'h1)
		rx(3'h7, 9'h0B1);
		`CHK(empty_n, 1'h0)
		rx(3'h5, 9'h0B2);
		// empty offset 0 with two words stored: almost-empty rises on 2nd read edge
		i_host.wr(2'h0, 9'h000);
		i_host.wr(2'h0, 9'h000);
		i_host.wr(2'h2, 9'h0B3);
		i_host.wr(2'h2, 9'h0B4);
		i_host.rd(3'h7);
		`CHK(ae_n, 1'h0)
		i_host.rd(3'h7);
		`CHK({ae_n, dout}, {1'h1, 9'h0B2})
		// largest full offset puts the level at one word: almost-full falls late
		i_host.wr(2'h0, 9'h1FF);
		i_host.wr(2'h0, 9'h01F);
		i_host.wr(2'h1, 9'h000);
		`CHK(af_n, 1'h1)
		i_host.wr(2'h1, 9'h000);
		`CHK({full_n, af_n}, 2'h2)
		end_of_test();
	end
endmodule
